// File: rtl/reset_output_and_config_latch.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Contract
// - reset_out_n goes low at the start of every kind of reset.
// - reset_out_n stays low until the end-of-initialisation command completes.
// - setting bit 3 of system_config_reg enables bidirectional reset.
// - every reset sequence clears the bidirectional reset enable.
// - setting the enable is ignored once end of initialisation has completed.
// - low powerdown pin while reset pin low stops pulling, reset becomes asynchronous.
// - with bidirectional enabled, reset pin pulled low during whole internal sequence.
// - pull on reset pin released before the cpu starts fetching.
// - weak pull-down on powerdown pin follows a low reset pin.
// - powerdown configuration bit turns on the pull-up at sequence end.
// - hardware reset is asynchronous if powerdown pin low, else synchronous.
// - software and watchdog resets latch only strap bits high 4..0, low 7..6.
// - short hardware reset latches all strap bits except the clock options.
// - long hardware and power-on resets latch all sixteen strap bits.
// - strap high byte lands in the low byte of latched_boot_config.
// - strap fields routed to clock, port logic and bus_config_zero.
// - bidirectional software or watchdog reset still pulling when the sequence starts is handled as a short hardware reset.
// - internal sequence lasts 512 clock periods before release and sampling.
module reset_output_and_config_latch (
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // reset pins
    input  wire logic        reset_in_n_in,
    output logic             reset_in_n_out,
    output logic             reset_in_n_oe_n,
    output logic             reset_out_n,
    // powerdown capacitor pin
    input  wire logic        powerdown_cap_pin,
    output logic             powerdown_cap_pulldown,
    output logic             powerdown_cap_pullup,
    // straps and events
    input  wire logic [15:0] boot_strap_port,
    input  wire logic        external_access_n,
    input  wire logic        watchdog_overflow,
    // towards the rest of the chip
    output logic             core_reset,
    output logic             reset_is_async,
    output logic      [2:0]  clock_option_field,
    output logic      [1:0]  segment_line_select,
    output logic      [1:0]  chip_select_count,
    output logic             write_config_strap,
    output logic             boot_loader_strap,
    output logic             adapt_mode_strap,
    output logic      [15:0] bus_config_zero
);
    typedef enum logic [2:0] {
        ST_DETECT,
        ST_SEQUENCE,
        ST_SETTLE,
        ST_EXTEND,
        ST_LATCH,
        ST_RUN
    } state_t;

    state_t                     state_r;
    state_t                     state_nxt;
    reset_seq_pkg::reset_kind_t kind_r;
    reset_seq_pkg::reset_kind_t kind_nxt;
    logic [reset_seq_pkg::CNT_W-1:0] cnt_r;
    logic [reset_seq_pkg::CNT_W-1:0] cnt_nxt;
    logic [1:0]  low_cnt_r;
    logic        reset_in_n_meta_r;
    logic        reset_in_n_sync_r;
    logic        rpd_meta_r;
    logic        rpd_sync_r;
    logic        ea_meta_r;
    logic        ea_sync_r;
    logic        bidir_r;
    logic        pwd_cfg_r;
    logic        eoi_done_r;
    logic        pull_r;
    logic        async_r;
    logic        pullup_r;
    logic        bus_active_r;
    logic        latch_len_r;
    logic [15:0] rdata_r;
    logic [15:0] strap_q;
    logic [15:0] latch_mask;
    logic        hw_request;
    logic        sw_request;
    logic        start_reset;
    logic        wr_syscfg;
    logic        wr_cmd;
    logic        cmd_eoi;
    logic        latch_en;
    logic        seq_done;
    logic        settle_done;
    logic        latch_done;
    logic        rpd_abort;
    logic [15:0] syscfg_view;
    logic [15:0] status_view;
    logic [15:0] rdata_nxt;

    function automatic logic is_soft(input reset_seq_pkg::reset_kind_t k);
        return (k == reset_seq_pkg::KIND_SOFTWARE) || (k == reset_seq_pkg::KIND_WATCHDOG);
    endfunction

    // pins pass two flops each
    always_ff @(posedge clk) begin
        reset_in_n_meta_r <= reset_in_n_in;
        reset_in_n_sync_r <= reset_in_n_meta_r;
        rpd_meta_r   <= powerdown_cap_pin;
        rpd_sync_r   <= rpd_meta_r;
        ea_meta_r    <= external_access_n;
        ea_sync_r    <= ea_meta_r;
    end

    // pin low for the detect time is a hardware request
    always_ff @(posedge clk) begin
        if (rst) begin
            low_cnt_r <= 2'h0;
        end else if (reset_in_n_sync_r) begin
            low_cnt_r <= 2'h0;
        end else if (low_cnt_r != 2'(reset_seq_pkg::DETECT_CYCLES)) begin
            low_cnt_r <= low_cnt_r + 2'h1;
        end
    end

    // register decode
    assign wr_syscfg  = reg_wr && (reg_addr == reset_seq_pkg::OFS_SYSTEM_CONFIG);
    assign wr_cmd     = reg_wr && (reg_addr == reset_seq_pkg::OFS_COMMAND);
    assign cmd_eoi    = wr_cmd && reg_wdata[reset_seq_pkg::BIT_CMD_END_OF_INIT] && (state_r == ST_RUN);
    assign sw_request = wr_cmd && reg_wdata[reset_seq_pkg::BIT_CMD_SOFT_RESET] && (state_r == ST_RUN);

    // glitches shorter than the detect time are ignored, relying on the board
    assign hw_request  = (low_cnt_r == 2'(reset_seq_pkg::DETECT_CYCLES));
    assign start_reset = (state_r == ST_RUN) && (hw_request || sw_request || watchdog_overflow);

    // sequencing terms
    assign seq_done    = (cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::SEQ_CYCLES - 1));
    assign settle_done = (cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::SETTLE_CYCLES - 1));
    assign latch_done  = (cnt_r == reset_seq_pkg::CNT_W'(reset_seq_pkg::LATCH_CYCLES - 1));
    assign rpd_abort   = !rpd_sync_r && (!reset_in_n_sync_r || pull_r);
    assign latch_en    = (state_r == ST_LATCH) && latch_done;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        cnt_nxt   = cnt_r + reset_seq_pkg::CNT_W'(1);
        unique case (state_r)
            ST_DETECT: begin
                cnt_nxt   = '0;
                state_nxt = ST_SEQUENCE;
            end
            ST_SEQUENCE: begin
                if (seq_done) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // synced pin needs a few cycles to show the release
                if (settle_done) begin
                    cnt_nxt = '0;
                    if (!reset_in_n_sync_r) begin
                        state_nxt = ST_EXTEND;
                        if (kind_r != reset_seq_pkg::KIND_POWER_ON) begin
                            kind_nxt = reset_seq_pkg::KIND_LONG_HW;
                        end
                    end else begin
                        state_nxt = ST_LATCH;
                    end
                end
            end
            ST_EXTEND: begin
                cnt_nxt = '0;
                if (reset_in_n_sync_r) begin
                    state_nxt = ST_LATCH;
                end
            end
            ST_LATCH: begin
                if (latch_done) begin
                    cnt_nxt   = '0;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_nxt = '0;
                if (start_reset) begin
                    state_nxt = ST_DETECT;
                    if (hw_request) begin
                        kind_nxt = reset_seq_pkg::KIND_SHORT_HW;
                    end else if (sw_request) begin
                        kind_nxt = reset_seq_pkg::KIND_SOFTWARE;
                    end else begin
                        kind_nxt = reset_seq_pkg::KIND_WATCHDOG;
                    end
                end
            end
        endcase
        // our own pull turns a soft reset into a hardware one
        if ((state_r == ST_SEQUENCE) && pull_r && is_soft(kind_r)) begin
            kind_nxt = reset_seq_pkg::KIND_SHORT_HW;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_SEQUENCE;
            kind_r  <= reset_seq_pkg::KIND_POWER_ON;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // open-drain pull on the reset pin, only for the internal sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            pull_r <= 1'b0;
        end else if (start_reset) begin
            pull_r <= bidir_r;
        end else if (rpd_abort || (state_r == ST_SEQUENCE && seq_done)) begin
            pull_r <= 1'b0;
        end
    end

    // async flavour; power-on starts from a discharged cap
    always_ff @(posedge clk) begin
        if (rst) begin
            async_r <= 1'b1;
        end else if (start_reset) begin
            async_r <= hw_request && !rpd_sync_r;
        end else if (state_r != ST_RUN && rpd_abort) begin
            async_r <= 1'b1;
        end else if (state_r == ST_SETTLE && settle_done && reset_in_n_sync_r) begin
            async_r <= async_r || !rpd_sync_r;
        end
    end

    // bidir enable and powerdown configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            bidir_r   <= reset_seq_pkg::SYSCFG_RESET[reset_seq_pkg::BIT_BIDIR_ENABLE];
            pwd_cfg_r <= reset_seq_pkg::SYSCFG_RESET[reset_seq_pkg::BIT_POWERDOWN_CFG];
        end else if (start_reset) begin
            bidir_r   <= 1'b0;
        end else if (wr_syscfg) begin
            // late attempts to set the enable are dropped; clearing always works
            if (!eoi_done_r || !reg_wdata[reset_seq_pkg::BIT_BIDIR_ENABLE]) begin
                bidir_r <= reg_wdata[reset_seq_pkg::BIT_BIDIR_ENABLE];
            end
            pwd_cfg_r <= reg_wdata[reset_seq_pkg::BIT_POWERDOWN_CFG];
        end
    end

    // end of initialisation gates the reset output
    always_ff @(posedge clk) begin
        if (rst) begin
            eoi_done_r <= 1'b0;
        end else if (start_reset) begin
            eoi_done_r <= 1'b0;
        end else if (cmd_eoi) begin
            eoi_done_r <= 1'b1;
        end
    end

    // pull-up on the powerdown pin once the sequence is over
    always_ff @(posedge clk) begin
        if (rst || start_reset) begin
            pullup_r <= 1'b0;
        end else if (latch_en) begin
            pullup_r <= pwd_cfg_r;
        end
    end

    // strap sampling mask by reset kind
    assign latch_mask = (kind_r == reset_seq_pkg::KIND_SHORT_HW) ? reset_seq_pkg::MASK_SHORT_HW :
                        is_soft(kind_r) ? reset_seq_pkg::MASK_SOFT_WD :
                        reset_seq_pkg::MASK_LONG_HW;

    strap_capture u_strap (
        .clk        (clk),
        .rst        (rst),
        .strap_pin  (boot_strap_port),
        .latch_en   (latch_en),
        .latch_mask (latch_mask),
        .strap_q    (strap_q)
    );

    // bus-active and latch-lengthen copy the access pin at latch
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_active_r <= 1'b0;
            latch_len_r  <= 1'b0;
        end else if (latch_en) begin
            bus_active_r <= ea_sync_r;
            latch_len_r  <= ea_sync_r;
        end
    end

    // field routing of the latched straps
    assign clock_option_field  = strap_q[reset_seq_pkg::POS_CLOCK_OPTION +: 3];
    assign segment_line_select = strap_q[reset_seq_pkg::POS_SEGMENT_SEL +: 2];
    assign chip_select_count   = strap_q[reset_seq_pkg::POS_CHIP_SEL_CNT +: 2];
    assign write_config_strap  = strap_q[reset_seq_pkg::BIT_WRITE_CFG];
    assign boot_loader_strap   = strap_q[reset_seq_pkg::BIT_BOOT_LOADER];
    assign adapt_mode_strap    = strap_q[reset_seq_pkg::BIT_ADAPT_MODE];

    always_comb begin
        bus_config_zero = 16'h0000;
        bus_config_zero[reset_seq_pkg::POS_BUS_TYPE +: 2]    = strap_q[reset_seq_pkg::POS_BUS_TYPE_STR +: 2];
        bus_config_zero[reset_seq_pkg::BIT_BUS_ACTIVE_FIRST] = bus_active_r;
        bus_config_zero[reset_seq_pkg::BIT_LATCH_LENGTHEN]   = latch_len_r;
    end

    // read views
    always_comb begin
        syscfg_view = 16'h0000;
        syscfg_view[reset_seq_pkg::BIT_BIDIR_ENABLE]  = bidir_r;
        syscfg_view[reset_seq_pkg::BIT_POWERDOWN_CFG] = pwd_cfg_r;
    end
    assign status_view = {8'h00, 1'b0, kind_r, async_r, pull_r, eoi_done_r, core_reset};

    // unmapped addresses read as zero
    always_comb begin
        unique case (reg_addr)
            reset_seq_pkg::OFS_SYSTEM_CONFIG: rdata_nxt = syscfg_view;
            reset_seq_pkg::OFS_BOOT_CONFIG:   rdata_nxt = {8'h00, strap_q[15:8]};
            reset_seq_pkg::OFS_BUS_CONFIG:    rdata_nxt = bus_config_zero;
            reset_seq_pkg::OFS_RESET_STATUS:  rdata_nxt = status_view;
            default:                          rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // pin and core outputs
    assign reg_rdata              = rdata_r;
    assign reset_out_n            = eoi_done_r;
    assign reset_in_n_out         = 1'b0;
    assign reset_in_n_oe_n        = !pull_r;
    assign powerdown_cap_pulldown = !reset_in_n_sync_r;
    assign powerdown_cap_pullup   = pullup_r;
    assign core_reset             = (state_r != ST_RUN);
    assign reset_is_async         = async_r;
endmodule

// File: rtl/reset_seq_pkg.sv
package reset_seq_pkg;
    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register offsets (word index)
    localparam logic [3:0] OFS_SYSTEM_CONFIG  = 4'h0;
    localparam logic [3:0] OFS_BOOT_CONFIG    = 4'h1;
    localparam logic [3:0] OFS_BUS_CONFIG     = 4'h2;
    localparam logic [3:0] OFS_RESET_STATUS   = 4'h3;
    localparam logic [3:0] OFS_COMMAND        = 4'h4;

    // system_config_reg fields
    localparam int BIT_BIDIR_ENABLE  = 3;
    localparam int BIT_POWERDOWN_CFG = 5;
    localparam logic [15:0] SYSCFG_RESET = 16'h0000;

    // command fields (write only, self clearing)
    localparam int BIT_CMD_END_OF_INIT = 0;
    localparam int BIT_CMD_SOFT_RESET  = 1;

    // bus_config_zero fields
    localparam int BIT_BUS_ACTIVE_FIRST = 10;
    localparam int BIT_LATCH_LENGTHEN   = 9;
    localparam int POS_BUS_TYPE         = 6;

    // strap field positions
    localparam int POS_CLOCK_OPTION = 13;
    localparam int POS_SEGMENT_SEL  = 11;
    localparam int POS_CHIP_SEL_CNT = 9;
    localparam int BIT_WRITE_CFG    = 8;
    localparam int POS_BUS_TYPE_STR = 6;
    localparam int BIT_BOOT_LOADER  = 4;
    localparam int BIT_ADAPT_MODE   = 1;

    // strap sampling masks per reset kind
    localparam logic [15:0] MASK_SOFT_WD   = 16'h1fc0;
    localparam logic [15:0] MASK_SHORT_HW  = 16'h1fff;
    localparam logic [15:0] MASK_LONG_HW   = 16'hffff;
    localparam logic [15:0] STRAP_RESET    = 16'h0000;

    // timing: half period unit is half the clock
    localparam int CLK_PERIOD_NS   = 50;
    localparam int HALF_PERIOD_NS  = CLK_PERIOD_NS / 2;
    localparam int SEQ_HALF_UNITS  = 1024;
    localparam int DETECT_HALF_UNITS = 4;
    localparam int LATCH_HALF_UNITS  = 8;
    localparam int SEQ_CYCLES    = (SEQ_HALF_UNITS * HALF_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int DETECT_CYCLES = (DETECT_HALF_UNITS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCH_CYCLES  = (LATCH_HALF_UNITS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles before the released pin is trusted
    localparam int SETTLE_CYCLES = 3;
    localparam int CNT_W = 10;

    // reset kinds
    typedef enum logic [2:0] {
        KIND_POWER_ON,
        KIND_LONG_HW,
        KIND_SHORT_HW,
        KIND_SOFTWARE,
        KIND_WATCHDOG
    } reset_kind_t;
endpackage

// File: rtl/strap_capture.sv
`timescale 1ns/1ps
// two-flop sync of the strap port plus masked latch
module strap_capture (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] strap_pin,
    input  wire logic        latch_en,
    input  wire logic [15:0] latch_mask,
    output logic      [15:0] strap_q
);
    logic [15:0] meta_r;
    logic [15:0] sync_r;
    logic [15:0] strap_nxt;

    // masked bits take the pin, the rest hold
    assign strap_nxt = (sync_r & latch_mask) | (strap_q & ~latch_mask);

    always_ff @(posedge clk) begin
        meta_r <= strap_pin;
        sync_r <= meta_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_q <= reset_seq_pkg::STRAP_RESET;
        end else if (latch_en) begin
            strap_q <= strap_nxt;
        end
    end
endmodule

// File: tb/board_reset_model.sv
`timescale 1ns/1ps
// board: button, pull-up, open drain, cap rc
module board_reset_model (
    input  wire logic button_n,
    input  wire logic drive_val,
    input  wire logic drive_oe_n,
    input  wire logic cap_charged,
    output logic      reset_pin_n,
    output logic      cap_level
);
    // wired-and with the board pull-up, so a released pin reads high
    assign reset_pin_n = button_n & (drive_oe_n | drive_val);
    // cap is charged or flat; the weak pull-down is too slow to matter
    assign cap_level = cap_charged;
endmodule

// File: tb/reset_output_and_config_latch_properties.sv
`timescale 1ns/1ps
module reset_output_and_config_latch_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reset_in_n_in,
    input wire logic        reset_in_n_oe_n,
    input wire logic        reset_out_n,
    input wire logic        powerdown_cap_pulldown,
    input wire logic        powerdown_cap_pullup,
    input wire logic        core_reset,
    input wire logic [2:0]  clock_option_field,
    input wire logic [1:0]  segment_line_select,
    input wire logic [1:0]  chip_select_count,
    input wire logic        write_config_strap,
    input wire logic [15:0] bus_config_zero
);
    logic       eoi_cmd;
    logic       boot_rd;
    logic [9:0] pull_cnt_r;
    // strobes the properties key on
    assign eoi_cmd = reg_wr && reg_addr == reset_seq_pkg::OFS_COMMAND && reg_wdata[0];
    assign boot_rd = reg_rd && reg_addr == reset_seq_pkg::OFS_BOOT_CONFIG;
    // pull length, saturating so it cannot wrap
    always_ff @(posedge clk) begin
        if (rst || reset_in_n_oe_n) begin
            pull_cnt_r <= 10'h000;
        end else if (pull_cnt_r != 10'h3ff) begin
            pull_cnt_r <= pull_cnt_r + 10'h001;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_OUT_LOW_IN_SEQ: assert property (core_reset |-> !reset_out_n)
        else $error("out high in seq");
    AST_OUT_RISE_CAUSE: assert property ($rose(reset_out_n) |-> $past(eoi_cmd) && !$past(core_reset))
        else $error("out rose early");
    AST_OUT_RISE_ON_EOI: assert property (eoi_cmd && !core_reset |=> reset_out_n)
        else $error("out not released");
    AST_PULL_IN_SEQ: assert property (!reset_in_n_oe_n |-> core_reset)
        else $error("pull outside seq");
    AST_PULL_START: assert property ($fell(reset_in_n_oe_n) |-> $rose(core_reset))
        else $error("pull start late");
    AST_PULL_LEN: assert property (pull_cnt_r <= 10'h202)
        else $error("pull too long");
    AST_PULLDOWN: assert property (powerdown_cap_pulldown == !$past(reset_in_n_in, 2))
        else $error("cap pulldown wrong");
    AST_BOOT_READ: assert property (boot_rd && !core_reset |=>
        reg_rdata == {8'h00, clock_option_field, segment_line_select, chip_select_count, write_config_strap})
        else $error("boot read wrong");
    AST_BUS_CFG: assert property (!core_reset |-> bus_config_zero[10] == bus_config_zero[9]
        && (bus_config_zero & 16'hf93f) == 16'h0000)
        else $error("bus config wrong");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("rdata not idle");
    AST_PULLUP_AT_END: assert property ($rose(powerdown_cap_pullup) |-> $past(core_reset))
        else $error("pullup not at end");
    cover property ($rose(reset_out_n));
    cover property ($fell(reset_in_n_oe_n));
    cover property ($fell(core_reset));
endmodule
bind reset_output_and_config_latch reset_output_and_config_latch_properties reset_output_and_config_latch_properties_i (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reset_in_n_in, .reset_in_n_oe_n, .reset_out_n,
    .powerdown_cap_pulldown, .powerdown_cap_pullup, .core_reset, .clock_option_field, .segment_line_select,
    .chip_select_count, .write_config_strap, .bus_config_zero);

// File: tb/reset_output_and_config_latch_test.sv
`timescale 1ns/1ps
module reset_output_and_config_latch_test;
    logic        clk;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        pin_n;
    logic        pin_val;
    logic        pin_oe_n;
    logic        reset_out_n;
    logic        cap_level;
    logic        cap_pd;
    logic        cap_pu;
    logic [15:0] strap;
    logic        ea_n;
    logic        wdog;
    logic        core_reset;
    logic        is_async;
    logic [2:0]  clk_opt;
    logic [1:0]  seg_sel;
    logic [1:0]  cs_cnt;
    logic        wr_cfg;
    logic        boot_ldr;
    logic        adapt;
    logic [15:0] bus_cfg;
    logic        button_n;
    logic        cap_charged;
    logic [15:0] d;
    int          errors;
    int          num_checks;
    int          n;
    reset_output_and_config_latch reset_output_and_config_latch_i (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reset_in_n_in(pin_n),
        .reset_in_n_out(pin_val), .reset_in_n_oe_n(pin_oe_n), .reset_out_n, .powerdown_cap_pin(cap_level),
        .powerdown_cap_pulldown(cap_pd), .powerdown_cap_pullup(cap_pu), .boot_strap_port(strap),
        .external_access_n(ea_n), .watchdog_overflow(wdog), .core_reset, .reset_is_async(is_async),
        .clock_option_field(clk_opt), .segment_line_select(seg_sel), .chip_select_count(cs_cnt),
        .write_config_strap(wr_cfg), .boot_loader_strap(boot_ldr), .adapt_mode_strap(adapt),
        .bus_config_zero(bus_cfg));
    board_reset_model board_reset_model_i (
        .button_n, .drive_val(pin_val), .drive_oe_n(pin_oe_n), .cap_charged, .reset_pin_n(pin_n), .cap_level);
    // 20 MHz clock
    always #25 clk = ~clk;
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    // data stands one cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        check(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    // bounded wait for the run state
    task automatic wait_run;
        repeat (8) @(posedge clk);
        n = 0;
        while (core_reset !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
        check_bit("core_reset", 1'b0, core_reset);
    endtask
    task automatic stop_test;
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, about six times the run
    initial begin
        #(20000 * 50);
        errors++;
        stop_test;
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        button_n = 1'b1;
        cap_charged = 1'b1;
        strap = 16'ha5c3;
        ea_n = 1'b1;
        wdog = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check_bit("out_n", 1'b0, reset_out_n);
        wait_run;
        rd(reset_seq_pkg::OFS_BOOT_CONFIG, d);
        check("boot", 16'h00a5, d);
        check("bus_cfg", 16'h06c0, bus_cfg);
        check("fields", 16'h0015, {11'h000, clk_opt, boot_ldr, adapt});
        check_bit("pulldown", 1'b0, cap_pd);
        rd(4'hf, d);
        check("unmapped", 16'h0000, d);
        wr(reset_seq_pkg::OFS_BOOT_CONFIG, 16'hffff);
        rd(reset_seq_pkg::OFS_BOOT_CONFIG, d);
        check("boot_ro", 16'h00a5, d);
        wr(reset_seq_pkg::OFS_SYSTEM_CONFIG, 16'h0008);
        rd(reset_seq_pkg::OFS_SYSTEM_CONFIG, d);
        check("sys_set", 16'h0008, d);
        wr(reset_seq_pkg::OFS_COMMAND, 16'h0001);
        @(posedge clk);
        #1;
        check_bit("out_n", 1'b1, reset_out_n);
        wr(reset_seq_pkg::OFS_SYSTEM_CONFIG, 16'h0000);
        wr(reset_seq_pkg::OFS_SYSTEM_CONFIG, 16'h0008);
        rd(reset_seq_pkg::OFS_SYSTEM_CONFIG, d);
        check("sys_late", 16'h0000, d);
        // software reset, no pull: middle strap bits only
        @(posedge clk);
        strap <= 16'h3a18;
        wr(reset_seq_pkg::OFS_COMMAND, 16'h0002);
        @(posedge clk);
        #1;
        check_bit("out_n", 1'b0, reset_out_n);
        check_bit("oe_n", 1'b1, pin_oe_n);
        wait_run;
        rd(reset_seq_pkg::OFS_BOOT_CONFIG, d);
        check("boot", 16'h00ba, d);
        check("bus_cfg", 16'h0600, bus_cfg);
        check("fields", 16'h0015, {11'h000, clk_opt, boot_ldr, adapt});
        // pulled watchdog reset becomes short hardware
        wr(reset_seq_pkg::OFS_SYSTEM_CONFIG, 16'h0028);
        strap <= 16'h4c55;
        @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        @(posedge clk);
        #1;
        check_bit("oe_n", 1'b0, pin_oe_n);
        repeat (3) @(posedge clk);
        #1;
        check_bit("pulldown", 1'b1, cap_pd);
        rd(reset_seq_pkg::OFS_SYSTEM_CONFIG, d);
        check("sys_clr", 16'h0020, d);
        n = 0;
        while (pin_oe_n === 1'b0 && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit("pull_len", 1'b1, n >= 503 && n <= 508);
        check_bit("core_reset", 1'b1, core_reset);
        wait_run;
        check_bit("pullup", 1'b1, cap_pu);
        rd(reset_seq_pkg::OFS_BOOT_CONFIG, d);
        check("boot", 16'h00ac, d);
        check("bus_cfg", 16'h0640, bus_cfg);
        check("fields", 16'h0016, {11'h000, clk_opt, boot_ldr, adapt});
        rd(reset_seq_pkg::OFS_RESET_STATUS, d);
        check("kind", 16'h0002, {13'h0000, d[6:4]});
        // long hardware reset, cap charged: all bits, synchronous
        @(posedge clk);
        strap <= 16'he701;
        button_n <= 1'b0;
        repeat (700) @(posedge clk);
        button_n <= 1'b1;
        wait_run;
        rd(reset_seq_pkg::OFS_BOOT_CONFIG, d);
        check("boot", 16'h00e7, d);
        check("fields", 16'h001c, {11'h000, clk_opt, boot_ldr, adapt});
        check_bit("async", 1'b0, is_async);
        // short pulse, cap flat: asynchronous, access pin low
        @(posedge clk);
        cap_charged <= 1'b0;
        ea_n <= 1'b0;
        strap <= 16'h1f80;
        button_n <= 1'b0;
        repeat (4) @(posedge clk);
        button_n <= 1'b1;
        wait_run;
        check_bit("async", 1'b1, is_async);
        check("bus_cfg", 16'h0080, bus_cfg);
        // pull with a flat cap is dropped
        wr(reset_seq_pkg::OFS_SYSTEM_CONFIG, 16'h0008);
        wr(reset_seq_pkg::OFS_COMMAND, 16'h0002);
        repeat (8) @(posedge clk);
        #1;
        check_bit("oe_n", 1'b1, pin_oe_n);
        check_bit("async", 1'b1, is_async);
        wait_run;
        stop_test;
    end
endmodule
